// [hdl/ocs_config_store.sv]
`timescale 1ns/10ps
`default_nettype none
// configuration store: shadow latches, fuses and output decode
module ocs_config_store
	import ocs_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic FUSE_BLANK_N,
	input wire logic RD_MODE,
	input wire logic TAMPER_VARIANT,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_BYTE,
	output logic CMD_READY,
	output logic CMD_DONE,
	output logic CMD_IGNORED,
	output logic TEST_LOCK,
	output logic CLOCK_RANGE,
	output logic EXTRA_GAIN,
	output logic LOW_RATE_PULSE,
	output logic [1:0] SENSOR_SELECT,
	output logic [1:0] STEPPER_DIV,
	output logic TEST_MODE_EN,
	output logic OTP_PRECHARGE,
	output logic [13:0] CLK_NOMINAL_KHZ,
	output logic [8:0] LED_DIVIDE,
	output logic [1:0] PRI_SENSOR_TYPE,
	output logic [5:0] PRI_GAIN,
	output logic SEC_ENABLE,
	output logic [1:0] SEC_SENSOR_TYPE,
	output logic [5:0] SEC_GAIN
);

	// pin synchronisers, first stage read only by second
	logic rd_meta_reg;
	logic rd_sync_reg;
	logic tamp_meta_reg;
	logic tamp_sync_reg;

	// command engine
	ocs_state_t state_reg;
	ocs_state_t state_next;
	logic [8:0] burn_cnt_reg;
	logic [8:0] burn_cnt_next;
	logic done_reg;
	logic ign_reg;

	// storage
	logic [63:0] shadow_reg; // volatile latches
	logic [63:0] fuse_q; // anti-fuse cells
	logic [63:0] eff; // selected source

	// registered outputs
	logic lock_out_reg;
	logic clk_out_reg;
	logic gain_out_reg;
	logic low_out_reg;
	logic [1:0] sens_out_reg;
	logic [1:0] step_out_reg;
	logic test_en_reg;
	logic prech_reg;
	logic [13:0] khz_reg;
	logic [8:0] div_reg;
	logic [1:0] pri_type_reg;
	logic [5:0] pri_gain_reg;
	logic sec_en_reg;
	logic [1:0] sec_type_reg;
	logic [5:0] sec_gain_reg;

	// command field decode
	wire [5:0] cmd_addr = CMD_BYTE[ADDR_W-1:0];
	wire cmd_val = CMD_BYTE[CMD_VAL_POS];
	wire cmd_perm = CMD_BYTE[CMD_PERM_POS];
	wire idle = (state_reg == ST_IDLE);
	wire take = CMD_VALID && idle;
	wire fuse_lock = fuse_q[ADDR_TEST_LOCK]; // permanent lock
	wire addr_ok = DEFINED_MASK[cmd_addr];
	wire accept = take && !fuse_lock && addr_ok;
	wire reject = take && !accept;
	wire shadow_we = accept && !cmd_perm;
	wire burn_go = accept && cmd_perm && cmd_val;
	wire blank_done = accept && cmd_perm && !cmd_val;
	wire burn_end = (state_reg == ST_BURN) && (burn_cnt_reg == BURN_LAST);

	// source select; lock takes latches out of service
	wire use_shadow = rd_sync_reg && !fuse_lock;
	assign eff = use_shadow ? shadow_reg : fuse_q;

	// effective fields
	wire e_lock = eff[ADDR_TEST_LOCK];
	wire e_clk = eff[ADDR_CLOCK_RANGE];
	wire e_gain = eff[ADDR_EXTRA_GAIN];
	wire e_low = eff[ADDR_LOW_RATE];
	wire [1:0] e_sens = {eff[ADDR_SENSOR_HI], eff[ADDR_SENSOR_LO]};
	wire [1:0] e_step = {eff[ADDR_STEP_HI], eff[ADDR_STEP_LO]};

	// ready only while no fuse burn runs
	assign CMD_READY = idle;
	assign CMD_DONE = done_reg;
	assign CMD_IGNORED = ign_reg;

	// synchronise the mode and variant pins
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			rd_meta_reg <= 1'b0;
			rd_sync_reg <= 1'b0;
			tamp_meta_reg <= 1'b0;
			tamp_sync_reg <= 1'b0;
		end else begin
			rd_meta_reg <= RD_MODE;
			rd_sync_reg <= rd_meta_reg;
			tamp_meta_reg <= TAMPER_VARIANT;
			tamp_sync_reg <= tamp_meta_reg;
		end
	end

	// shadow latch per bit, cleared by every reset
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BITS; gi = gi + 1) begin : g_shadow
			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					shadow_reg[gi] <= SHADOW_RESET[gi];
				end else if (shadow_we && (cmd_addr == 6'(gi))) begin
					shadow_reg[gi] <= cmd_val;
				end
			end
		end
	endgenerate

	// fuse cells, programmed one bit at a time
	ocs_fuse_bank u_fuse (
		.clk(CLK_SYS),
		.blank_n(FUSE_BLANK_N),
		.prog_stb(burn_go),
		.prog_addr(cmd_addr),
		.fuse_q(fuse_q)
	);

	// next state of the command engine
	always_comb begin
		state_next = state_reg;
		burn_cnt_next = burn_cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				// start the burn timer on a fuse write
				if (burn_go) begin
					state_next = ST_BURN;
					burn_cnt_next = BURN_ZERO;
				end
			end
			ST_BURN: begin
				// hold off commands until the cell is written
				if (burn_end) begin
					state_next = ST_IDLE;
				end else begin
					burn_cnt_next = burn_cnt_reg + 9'h001;
				end
			end
			default: begin
				state_next = ST_IDLE;
				burn_cnt_next = BURN_ZERO;
			end
		endcase
	end

	// command engine registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			burn_cnt_reg <= BURN_ZERO;
		end else begin
			state_reg <= state_next;
			burn_cnt_reg <= burn_cnt_next;
		end
	end

	// completion and refusal pulses
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			done_reg <= 1'b0;
			ign_reg <= 1'b0;
		end else begin
			done_reg <= shadow_we || blank_done || burn_end;
			ign_reg <= reject;
		end
	end

	// test lock meaning
	wire test_en = !e_lock;
	wire prech = !e_lock && !rd_sync_reg;

	// clock range decode
	wire [13:0] khz = e_clk ? CLK_HIGH_KHZ : CLK_LOW_KHZ;

	// indicator divide decode
	logic [8:0] div_sel;
	always_comb begin
		div_sel = DIV_FULL;
		if (e_low) begin
			case (e_step)
				2'h0: div_sel = DIV_64;
				2'h1: div_sel = DIV_128;
				2'h2: div_sel = DIV_32;
				default: div_sel = DIV_256;
			endcase
		end
	end

	// sensor type and gain decode
	logic [1:0] pri_type;
	logic [5:0] pri_gain;
	logic [1:0] sec_type;
	logic [5:0] sec_gain;
	always_comb begin
		pri_type = SENS_ROGOWSKI;
		pri_gain = GAIN_X8;
		case (e_sens)
			2'h0: begin
				// coil, extra gain doubles
				pri_type = SENS_ROGOWSKI;
				pri_gain = e_gain ? GAIN_X16 : GAIN_X8;
			end
			2'h1: begin
				// coil, high gain
				pri_type = SENS_ROGOWSKI;
				pri_gain = e_gain ? GAIN_X32 : GAIN_X24;
			end
			2'h2: begin
				// current transformer
				pri_type = SENS_CT;
				pri_gain = GAIN_X8;
			end
			default: begin
				// shunt, or transformer on the tamper variant
				pri_type = tamp_sync_reg ? SENS_CT : SENS_SHUNT;
				pri_gain = tamp_sync_reg ? GAIN_X8 : GAIN_X32;
			end
		endcase
		// secondary channel follows except in the last code
		sec_type = pri_type;
		sec_gain = pri_gain;
		if (e_sens == 2'h3) begin
			sec_type = SENS_SHUNT;
			sec_gain = GAIN_X32;
		end
	end

	// register the configuration outputs
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			lock_out_reg <= 1'b0;
			clk_out_reg <= 1'b0;
			gain_out_reg <= 1'b0;
			low_out_reg <= 1'b0;
			sens_out_reg <= 2'h0;
			step_out_reg <= 2'h0;
		end else begin
			lock_out_reg <= e_lock;
			clk_out_reg <= e_clk;
			gain_out_reg <= e_gain;
			low_out_reg <= e_low;
			sens_out_reg <= e_sens;
			step_out_reg <= e_step;
		end
	end

	// register the decoded outputs
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			// lock reads zero in reset, so test stays enabled and the inverse holds
			test_en_reg <= 1'b1;
			prech_reg <= 1'b0;
			khz_reg <= CLK_LOW_KHZ;
			div_reg <= DIV_FULL;
		end else begin
			test_en_reg <= test_en;
			prech_reg <= prech;
			khz_reg <= khz;
			div_reg <= div_sel;
		end
	end

	// register the channel outputs
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			pri_type_reg <= SENS_ROGOWSKI;
			pri_gain_reg <= GAIN_X8;
			sec_en_reg <= 1'b0;
			sec_type_reg <= SENS_ROGOWSKI;
			sec_gain_reg <= GAIN_X8;
		end else begin
			pri_type_reg <= pri_type;
			pri_gain_reg <= pri_gain;
			sec_en_reg <= tamp_sync_reg;
			sec_type_reg <= sec_type;
			sec_gain_reg <= sec_gain;
		end
	end

	// drive the ports
	assign TEST_LOCK = lock_out_reg;
	assign CLOCK_RANGE = clk_out_reg;
	assign EXTRA_GAIN = gain_out_reg;
	assign LOW_RATE_PULSE = low_out_reg;
	assign SENSOR_SELECT = sens_out_reg;
	assign STEPPER_DIV = step_out_reg;
	assign TEST_MODE_EN = test_en_reg;
	assign OTP_PRECHARGE = prech_reg;
	assign CLK_NOMINAL_KHZ = khz_reg;
	assign LED_DIVIDE = div_reg;
	assign PRI_SENSOR_TYPE = pri_type_reg;
	assign PRI_GAIN = pri_gain_reg;
	assign SEC_ENABLE = sec_en_reg;
	assign SEC_SENSOR_TYPE = sec_type_reg;
	assign SEC_GAIN = sec_gain_reg;

endmodule
`default_nettype wire

// [hdl/ocs_pkg.sv]
// What this block does
// - shadow latches take temporary writes, rewritable until the test lock fuse is programmed
// - fuse cells keep programmed ones, never revert
// - reset clears every shadow latch to zero
// - each bit: one latch, one fuse; blank reads zero
// - read mode picks shadow unless test lock fuse is programmed, else fuse drives outputs
// - byte command writes one bit by 6-bit address
// - programmed test lock ignores every later command
// - test lock zero: test, precharge when not in read mode; one: normal
// - clock range bit picks 4 or 8 MHz
// - low rate bit divides pulse rate per stepper select
// - sensor select picks sensor type and gain
// - power-on reset clears all functional state except the fuse cells
package ocs_pkg;

	// command byte layout
	localparam int CMD_W = 8;
	localparam int ADDR_W = 6;
	localparam int NUM_BITS = 64;
	localparam int CMD_VAL_POS = 7; // value written into the bit
	localparam int CMD_PERM_POS = 6; // 1 = program fuse, 0 = shadow latch

	// configuration bit addresses
	localparam logic [5:0] ADDR_TEST_LOCK = 6'h00;
	localparam logic [5:0] ADDR_CLOCK_RANGE = 6'h01;
	localparam logic [5:0] ADDR_EXTRA_GAIN = 6'h02;
	localparam logic [5:0] ADDR_LOW_RATE = 6'h03;
	localparam logic [5:0] ADDR_SENSOR_LO = 6'h05;
	localparam logic [5:0] ADDR_SENSOR_HI = 6'h06;
	localparam logic [5:0] ADDR_STEP_LO = 6'h0e;
	localparam logic [5:0] ADDR_STEP_HI = 6'h0f;

	// which addresses hold a defined bit
	localparam logic [63:0] DEFINED_MASK = 64'h0000_0000_0000_c06f;
	localparam logic [63:0] SHADOW_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] FUSE_BLANK = 64'h0000_0000_0000_0000;

	// fuse burn time, least time so rounded up
	localparam int CLK_PERIOD_PS = 25000;
	localparam int BURN_TIME_NS = 10;
	localparam int BURN_CYCLES = (BURN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BURN_CNT_W = 9;
	localparam logic [8:0] BURN_LAST = 9'(BURN_CYCLES - 1);
	localparam logic [8:0] BURN_ZERO = 9'h000;

	// nominal clock in kHz
	localparam logic [13:0] CLK_LOW_KHZ = 14'h0fa0; // 4000
	localparam logic [13:0] CLK_HIGH_KHZ = 14'h1f40; // 8000

	// indicator pulse divide ratios
	localparam logic [8:0] DIV_FULL = 9'h001;
	localparam logic [8:0] DIV_64 = 9'h040;
	localparam logic [8:0] DIV_128 = 9'h080;
	localparam logic [8:0] DIV_32 = 9'h020;
	localparam logic [8:0] DIV_256 = 9'h100;

	// current channel gains
	localparam logic [5:0] GAIN_X8 = 6'h08;
	localparam logic [5:0] GAIN_X16 = 6'h10;
	localparam logic [5:0] GAIN_X24 = 6'h18;
	localparam logic [5:0] GAIN_X32 = 6'h20;

	// sensor kinds
	typedef enum logic [1:0] {
		SENS_ROGOWSKI = 2'h0,
		SENS_CT = 2'h1,
		SENS_SHUNT = 2'h2
	} ocs_sensor_t;

	// command engine states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BURN = 2'b10
	} ocs_state_t;

endpackage

// [hdl/ocs_fuse_bank.sv]
`timescale 1ns/10ps
`default_nettype none
// anti-fuse array; only the blank strobe of the model empties it
module ocs_fuse_bank
	import ocs_pkg::*;
(
	input wire logic clk,
	input wire logic blank_n,
	input wire logic prog_stb,
	input wire logic [5:0] prog_addr,
	output logic [63:0] fuse_q
);

	// cells hold their state across the device reset
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BITS; gi = gi + 1) begin : g_cell
			// a cell only ever goes from blank to programmed
			always_ff @(posedge clk) begin
				if (!blank_n) begin
					fuse_q[gi] <= FUSE_BLANK[gi];
				end else if (prog_stb && (prog_addr == 6'(gi))) begin
					fuse_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// [test/ocs_config_store_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// watches the command port and the decoded outputs
module ocs_config_store_sva
	import ocs_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic RD_MODE,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_BYTE,
	input wire logic CMD_READY,
	input wire logic CMD_DONE,
	input wire logic CMD_IGNORED,
	input wire logic TEST_LOCK,
	input wire logic TEST_MODE_EN,
	input wire logic CLOCK_RANGE,
	input wire logic [13:0] CLK_NOMINAL_KHZ,
	input wire logic LOW_RATE_PULSE,
	input wire logic [1:0] STEPPER_DIV,
	input wire logic [8:0] LED_DIVIDE,
	input wire logic [1:0] SENSOR_SELECT
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// address holds a defined bit
	wire def_addr;
	assign def_addr = CMD_BYTE[5:0] inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h0e, 6'h0f};
	// command taken on this edge, accepted or refused
	sequence s_take;
		CMD_VALID && CMD_READY;
	endsequence
	// fuse source settled through the sync
	sequence s_fuse_src;
		(!RD_MODE) [*5];
	endsequence
	a_ack_one: assert property (s_take |-> ##[1:2] (CMD_DONE || CMD_IGNORED))
		else $error("command not answered");
	a_bad_addr: assert property (s_take ##0 !def_addr |=> CMD_IGNORED)
		else $error("undefined address not refused");
	a_lock_ignores: assert property (s_fuse_src ##0 (s_take and TEST_LOCK) |=> CMD_IGNORED)
		else $error("locked store took a command");
	a_lock_sticky: assert property (s_fuse_src ##0 TEST_LOCK |=> TEST_LOCK)
		else $error("programmed lock reverted");
	a_clk_range: assert property (CLK_NOMINAL_KHZ == (CLOCK_RANGE ? 14'h1f40 : 14'h0fa0))
		else $error("nominal clock wrong");
	a_led_div: assert property (LED_DIVIDE == (!LOW_RATE_PULSE ? 9'h001 :
		STEPPER_DIV == 2'h0 ? 9'h040 : STEPPER_DIV == 2'h1 ? 9'h080 :
		STEPPER_DIV == 2'h2 ? 9'h020 : 9'h100)) else $error("pulse divide wrong");
	a_test_mode: assert property (TEST_MODE_EN == !TEST_LOCK)
		else $error("test enable not inverse of lock");
	a_reset_state: assert property ($rose(RST_N) |-> !TEST_LOCK && !CLOCK_RANGE && CMD_READY)
		else $error("outputs not cleared by reset");
	a_burn_short: assert property (!CMD_READY |=> CMD_READY)
		else $error("burn longer than one cycle");
endmodule
bind ocs_config_store ocs_config_store_sva u_ocs_config_store_sva (.*);
`default_nettype wire

// [test/ocs_prog_model.sv]
`timescale 1ns/10ps
`default_nettype none
// programmer: offers one byte, holds it until taken or for 8 clocks at most
module ocs_prog_model (
	input wire logic clk,
	input wire logic ready,
	output logic valid,
	output logic [7:0] cmd
);
	initial begin
		valid = 1'b0;
		cmd = 8'h00;
	end
	// one bit written per byte command
	task automatic send(input logic [7:0] b, output bit ok);
		ok = 1'b0;
		valid <= 1'b1;
		cmd <= b;
		repeat (8) if (!ok) begin
			@(posedge clk);
			ok = ready;
		end
		// released bus shows the inverse, not the old byte
		valid <= 1'b0;
		cmd <= ~b;
	endtask
endmodule
`default_nettype wire

// [test/ocs_config_store_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("FAIL %0t got %h want %h", $time, a, e); end end
module ocs_config_store_tb_top;
	import ocs_pkg::*;
	logic CLK_SYS, RST_N, FUSE_BLANK_N, RD_MODE, TAMPER_VARIANT, CMD_VALID, CMD_READY;
	logic CMD_DONE, CMD_IGNORED, TEST_LOCK, CLOCK_RANGE, EXTRA_GAIN, LOW_RATE_PULSE;
	logic TEST_MODE_EN, OTP_PRECHARGE, SEC_ENABLE;
	logic [7:0] CMD_BYTE;
	logic [1:0] SENSOR_SELECT, STEPPER_DIV, PRI_SENSOR_TYPE, SEC_SENSOR_TYPE;
	logic [13:0] CLK_NOMINAL_KHZ;
	logic [8:0] LED_DIVIDE;
	logic [5:0] PRI_GAIN, SEC_GAIN;
	int fail_count = 0;
	int total_checks = 0;
	bit [63:0] sh, fu; // model latches and fuses
	ocs_config_store u_ocs_config_store (.*);
	ocs_prog_model u_ocs_prog_model (.clk(CLK_SYS), .ready(CMD_READY), .valid(CMD_VALID),
		.cmd(CMD_BYTE));
	initial begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	// effective bit: lock forces fuses
	function automatic bit e(int i);
		return (fu[0] || !RD_MODE) ? fu[i] : sh[i];
	endfunction
	// compare every configuration output against the model
	task automatic check_out;
		logic [1:0] ps, ty;
		logic [5:0] g;
		logic [8:0] ld;
		logic [41:0] got, want;
		repeat (5) @(posedge CLK_SYS);
		ps = {e(6), e(5)};
		ld = !e(3) ? 9'h001 : e(15) ? (e(14) ? 9'h100 : 9'h020) : (e(14) ? 9'h080 : 9'h040);
		ty = ps[1] ? ((ps[0] && !TAMPER_VARIANT) ? 2'h2 : 2'h1) : 2'h0;
		g = ps == 2'h0 ? (e(2) ? 6'h10 : 6'h08) : ps == 2'h1 ? (e(2) ? 6'h20 : 6'h18) :
			(ps == 2'h2 || TAMPER_VARIANT) ? 6'h08 : 6'h20;
		got = {TEST_LOCK, CLOCK_RANGE, EXTRA_GAIN, LOW_RATE_PULSE, SENSOR_SELECT, STEPPER_DIV,
			TEST_MODE_EN, OTP_PRECHARGE, CLK_NOMINAL_KHZ, LED_DIVIDE, PRI_SENSOR_TYPE, PRI_GAIN,
			SEC_ENABLE};
		want = {e(0), e(1), e(2), e(3), ps, e(15), e(14), !e(0), !e(0) && !RD_MODE,
			e(1) ? 14'h1f40 : 14'h0fa0, ld, ty, g, TAMPER_VARIANT};
		`CHK(got, want)
		`CHK({SEC_SENSOR_TYPE, SEC_GAIN}, (TAMPER_VARIANT && ps == 2'h3) ? 8'ha0 : {ty, g})
	endtask
	// one command through the programmer, then its answer
	task automatic cmd_go(input logic [7:0] b);
		bit ok, tk, ig;
		int a;
		a = b[5:0];
		ig = fu[0] || !(a inside {0, 1, 2, 3, 5, 6, 14, 15});
		repeat ($urandom_range(2)) @(posedge CLK_SYS);
		u_ocs_prog_model.send(b, tk);
		if (!ig && b[6]) fu[a] = fu[a] | b[7];
		else if (!ig) sh[a] = b[7];
		ok = 1'b0;
		repeat (8) if (!ok) begin
			@(posedge CLK_SYS);
			ok = CMD_DONE || CMD_IGNORED;
		end
		`CHK({tk, ok, CMD_DONE, CMD_IGNORED}, {2'b11, !ig, ig})
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		RST_N = 1'b0;
		FUSE_BLANK_N = 1'b0;
		RD_MODE = 1'b0;
		TAMPER_VARIANT = 1'b0;
		sh = '0;
		fu = '0;
		void'($urandom(32'heaa067c9));
		repeat (10) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		FUSE_BLANK_N <= 1'b1;
		check_out;
		`CHK(CMD_READY, 1'b1)
		// shadow source: every address, random values
		RD_MODE <= 1'b1;
		for (int i = 0; i < 64; i++) cmd_go({1'($urandom), 1'b0, 6'(i)});
		cmd_go(8'h83);
		// every sensor, divider and variant code
		for (int j = 0; j < 8; j++) begin
			TAMPER_VARIANT <= j[2];
			cmd_go({j[0], 7'h05});
			cmd_go({j[1], 7'h06});
			cmd_go({j[0], 7'h0e});
			cmd_go({j[1], 7'h0f});
			cmd_go({j[2], 7'h02});
			check_out;
		end
		// fuse source, blank then programmed
		RD_MODE <= 1'b0;
		check_out;
		cmd_go(8'hc1);
		cmd_go(8'h41);
		cmd_go(8'h01);
		check_out;
		// reset in mid-run clears latches, keeps fuses
		RD_MODE <= 1'b1;
		RST_N <= 1'b0;
		sh = '0;
		repeat (3) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		check_out;
		RD_MODE <= 1'b0;
		check_out;
		// lock, then everything refused
		cmd_go(8'hc0);
		check_out;
		cmd_go(8'h83);
		RD_MODE <= 1'b1;
		cmd_go(8'hc3);
		check_out;
		give_verdict;
	end
endmodule
`default_nettype wire
